// ==== logic/riu_pkg.sv ====
`default_nettype none
package riu_pkg;
  localparam int PC_W = 21;
  localparam int STK_DEPTH = 31;
  localparam int STK_PTR_W = 5;
  localparam logic [15:0] OP_IRQ_RET_BASE = 16'h0010;
  localparam logic [15:0] OP_SUB_RET_BASE = 16'h0012;
  localparam logic [15:0] OP_RET_MASK = 16'hFFFE;
  localparam logic [7:0] OP_LIT_RET_HI = 8'h0C;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [PC_W-1:0] PC_RST = 21'h00_0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [STK_PTR_W-1:0] PTR_RST = 5'h00;

  typedef enum logic [1:0] {RIU_NONE, RIU_IRQ_RET, RIU_LIT_RET, RIU_SUB_RET} riu_op_type;

  typedef struct packed {
    logic [7:0] working;
    logic [7:0] status;
    logic [7:0] bank;
  } riu_ctx_type;
endpackage : riu_pkg
`default_nettype wire

// ==== logic/riu_return_unit.sv ====
// Function
// - Decode interrupt return opcode, pop stack, load popped top into PC.
// - Interrupt return sets high or low priority global interrupt enable.
// - Select bit 1 restores working, status, bank from shadows; 0 leaves them.
// - Return instructions never change the PC upper and high latches.
// - Decode literal return, write 8-bit literal into working register.
// - Literal return also pops stack into PC in the same phase.
// - Decode subroutine return with select bit, pop to PC, no interrupt enable set.
// - A pop makes the entry below the discarded top the new top.
`default_nettype none
module riu_return_unit
  import riu_pkg::*;
(
  input  wire logic            CLK_I,
  input  wire logic            RST_I,
  input  wire logic [15:0]     INSTR_I,
  input  wire logic            INSTR_VALID_I,
  input  wire logic            PUSH_I,
  input  wire logic [PC_W-1:0] PUSH_ADDR_I,
  input  wire logic            IPEN_I,
  input  wire logic            HIGH_PRIO_ACTIVE_I,
  input  wire riu_ctx_type     SHADOW_I,
  input  wire riu_ctx_type     LIVE_I,
  output logic [PC_W-1:0]      PC_O,
  output logic                 PC_WE_O,
  output riu_ctx_type          CTX_O,
  output logic                 CTX_WE_O,
  output logic                 STATUS_WE_O,
  output logic                 HIGH_PRIO_GLOBAL_IRQ_ENABLE_O,
  output logic                 LOW_PRIO_GLOBAL_IRQ_ENABLE_O,
  output logic                 FLUSH_O,
  output logic [PC_W-1:0]      STACK_TOP_VALUE_O,
  output logic [STK_PTR_W-1:0] STACK_PTR_O,
  output logic [1:0]           PHASE_O
);

  function automatic riu_op_type decode_op(input logic [15:0] ins);
    if ((ins & OP_RET_MASK) == OP_IRQ_RET_BASE) begin
      return RIU_IRQ_RET;
    end else if ((ins & OP_RET_MASK) == OP_SUB_RET_BASE) begin
      return RIU_SUB_RET;
    end else if (ins[15:8] == OP_LIT_RET_HI) begin
      return RIU_LIT_RET;
    end
    return RIU_NONE;
  endfunction : decode_op

  function automatic logic stack_full(input logic [STK_PTR_W-1:0] ptr);
    return ptr == STK_PTR_W'(STK_DEPTH);
  endfunction : stack_full

  function automatic logic stack_empty(input logic [STK_PTR_W-1:0] ptr);
    return ptr == PTR_RST;
  endfunction : stack_empty

  logic [PC_W-1:0]      stack_ff [STK_DEPTH];
  logic [STK_PTR_W-1:0] ptr_ff;
  logic [STK_PTR_W-1:0] nxt_ptr;
  logic [1:0]           phase_ff;
  logic [1:0]           nxt_phase;
  riu_op_type           op_ff;
  riu_op_type           nxt_op;
  logic [15:0]          ins_ff;
  logic [15:0]          nxt_ins;
  logic                 bubble_ff;
  logic                 nxt_bubble;
  logic [PC_W-1:0]      pc_ff;
  logic [PC_W-1:0]      nxt_pc;
  logic                 pc_we_ff;
  logic                 nxt_pc_we;
  riu_ctx_type          ctx_ff;
  riu_ctx_type          nxt_ctx;
  logic                 ctx_we_ff;
  logic                 nxt_ctx_we;
  logic                 st_we_ff;
  logic                 nxt_st_we;
  logic                 hi_en_ff;
  logic                 nxt_hi_en;
  logic                 lo_en_ff;
  logic                 nxt_lo_en;
  logic                 pop;
  logic                 push_ok;
  logic                 wr_en;
  logic [PC_W-1:0]      top;

  // Empty stack reads as zero
  assign top = stack_empty(ptr_ff) ? PC_RST : stack_ff[ptr_ff - 5'h01];
  assign pop = (phase_ff == PHASE_Q4) && (op_ff != RIU_NONE);

  // Push dropped during a pop or when full
  assign push_ok = PUSH_I && !pop && !stack_full(ptr_ff);
  assign wr_en = push_ok && !RST_I;

  // Sequencing: phase count, captured opcode, refill bubble
  always_comb begin
    nxt_phase = phase_ff + 2'h1;
    nxt_op = op_ff;
    nxt_ins = ins_ff;
    nxt_bubble = bubble_ff;
    if (phase_ff == PHASE_Q1) begin
      // Word offered during the refill cycle is dropped
      if (bubble_ff) begin
        nxt_op = RIU_NONE;
        nxt_bubble = 1'b0;
      end else begin
        nxt_op = INSTR_VALID_I ? decode_op(INSTR_I) : RIU_NONE;
        nxt_ins = INSTR_I;
      end
    end
    if (pop) begin
      nxt_bubble = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      phase_ff <= PHASE_RST;
      op_ff <= RIU_NONE;
      ins_ff <= 16'h0000;
      bubble_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      op_ff <= nxt_op;
      ins_ff <= nxt_ins;
      bubble_ff <= nxt_bubble;
    end
  end

  // Results: popped address, context write-back, enable pulses
  always_comb begin
    nxt_pc = pc_ff;
    nxt_pc_we = 1'b0;
    // Unwritten fields carry the live values
    nxt_ctx = LIVE_I;
    nxt_ctx_we = 1'b0;
    nxt_st_we = 1'b0;
    nxt_hi_en = 1'b0;
    nxt_lo_en = 1'b0;
    if (pop) begin
      nxt_pc = top;
      nxt_pc_we = 1'b1;
      unique case (op_ff)
        RIU_LIT_RET: begin
          nxt_ctx.working = ins_ff[7:0];
          nxt_ctx_we = 1'b1;
        end
        RIU_IRQ_RET, RIU_SUB_RET: begin
          if (ins_ff[0]) begin
            nxt_ctx = SHADOW_I;
            nxt_ctx_we = 1'b1;
            nxt_st_we = 1'b1;
          end
          if (op_ff == RIU_IRQ_RET) begin
            nxt_hi_en = !IPEN_I || HIGH_PRIO_ACTIVE_I;
            nxt_lo_en = IPEN_I && !HIGH_PRIO_ACTIVE_I;
          end
        end
        RIU_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pc_ff <= PC_RST;
      pc_we_ff <= 1'b0;
      ctx_ff <= '0;
      ctx_we_ff <= 1'b0;
      st_we_ff <= 1'b0;
      hi_en_ff <= 1'b0;
      lo_en_ff <= 1'b0;
    end else begin
      pc_ff <= nxt_pc;
      pc_we_ff <= nxt_pc_we;
      ctx_ff <= nxt_ctx;
      ctx_we_ff <= nxt_ctx_we;
      st_we_ff <= nxt_st_we;
      hi_en_ff <= nxt_hi_en;
      lo_en_ff <= nxt_lo_en;
    end
  end

  // Stack pointer: a pop wins over a push
  always_comb begin
    nxt_ptr = ptr_ff;
    if (pop && !stack_empty(ptr_ff)) begin
      nxt_ptr = ptr_ff - 5'h01;
    end else if (push_ok) begin
      nxt_ptr = ptr_ff + 5'h01;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ptr_ff <= PTR_RST;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // Storage has no reset: slots at or above the pointer are never read
  always_ff @(posedge CLK_I) begin
    if (wr_en) begin
      stack_ff[ptr_ff] <= PUSH_ADDR_I;
    end
  end

  assign PC_O = pc_ff;
  assign PC_WE_O = pc_we_ff;
  assign CTX_O = ctx_ff;
  assign CTX_WE_O = ctx_we_ff;
  assign STATUS_WE_O = st_we_ff;
  assign HIGH_PRIO_GLOBAL_IRQ_ENABLE_O = hi_en_ff;
  assign LOW_PRIO_GLOBAL_IRQ_ENABLE_O = lo_en_ff;
  assign FLUSH_O = bubble_ff;
  assign STACK_TOP_VALUE_O = top;
  assign STACK_PTR_O = ptr_ff;
  assign PHASE_O = phase_ff;

endmodule : riu_return_unit
`default_nettype wire

// ==== verif/riu_regfile_model.sv ====
`default_nettype none
module riu_regfile_model
  import riu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire riu_ctx_type ctx_i,
  output riu_ctx_type      live_o
);
  always_ff @(posedge clk_i) if (we_i) live_o <= ctx_i;
endmodule : riu_regfile_model
`default_nettype wire

// ==== verif/riu_ret_assertions.sv ====
`default_nettype none
module riu_ret_assertions
  import riu_pkg::*;
(
  input wire logic [PC_W-1:0] PC_O,
  input wire logic [PC_W-1:0] STACK_TOP_VALUE_O,
  input wire logic [15:0]     INSTR_I,
  input wire logic [1:0]      PHASE_O,
  input wire logic [4:0]      STACK_PTR_O,
  input wire riu_ctx_type     CTX_O,
  input wire logic            CLK_I,
  input wire logic            RST_I,
  input wire logic            INSTR_VALID_I,
  input wire logic            IPEN_I,
  input wire logic            HIGH_PRIO_ACTIVE_I,
  input wire logic            PC_WE_O,
  input wire logic            CTX_WE_O,
  input wire logic            STATUS_WE_O,
  input wire logic            FLUSH_O,
  input wire logic            HIGH_PRIO_GLOBAL_IRQ_ENABLE_O,
  input wire logic            LOW_PRIO_GLOBAL_IRQ_ENABLE_O
);
  wire tk = PHASE_O == PHASE_Q1 && INSTR_VALID_I && !FLUSH_O;
  wire irq = (INSTR_I & OP_RET_MASK) == OP_IRQ_RET_BASE;
  wire lit = INSTR_I[15:8] == OP_LIT_RET_HI;
  wire ret = tk && (irq || lit || (INSTR_I & OP_RET_MASK) == OP_SUB_RET_BASE);
  wire [1:0] en = {HIGH_PRIO_GLOBAL_IRQ_ENABLE_O, LOW_PRIO_GLOBAL_IRQ_ENABLE_O};
  wire hi = !IPEN_I || HIGH_PRIO_ACTIVE_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  chk_ret_lat: assert property (ret |-> ##4 PC_WE_O) else $error("late pc write");
  chk_pop_top: assert property (PC_WE_O |-> PC_O == $past(STACK_TOP_VALUE_O))
    else $error("pc not old top");
  chk_flush_len: assert property ($rose(PC_WE_O) |-> FLUSH_O ##1 !PC_WE_O [*7])
    else $error("refill cycle not idle");
  chk_irq_enable: assert property (ret |-> ##4 (|en) == $past(irq, 4))
    else $error("enable set");
  chk_enable_one: assert property ($onehot0(en)) else $error("both enables");
  chk_enable_pick: assert property (ret && irq |-> ##4 en[1] == $past(hi, 4))
    else $error("wrong priority enable");
  chk_ptr_pop: assert property (PC_WE_O && $past(STACK_PTR_O) != 5'h00
    |-> STACK_PTR_O == $past(STACK_PTR_O) - 5'h01) else $error("pointer not lowered");
  chk_empty_pop: assert property (PC_WE_O && $past(STACK_PTR_O) == 5'h00
    |-> STACK_PTR_O == 5'h00 && PC_O == PC_RST) else $error("empty pop");
  chk_ctx_pair: assert property (STATUS_WE_O |-> CTX_WE_O) else $error("status alone");
  chk_sel_bit: assert property (ret && !lit
    |-> ##4 STATUS_WE_O == $past(INSTR_I[0], 4)) else $error("select bit");
  chk_lit_w: assert property (ret && lit |-> ##4 CTX_WE_O && !STATUS_WE_O
    && CTX_O.working == $past(INSTR_I[7:0], 4)) else $error("literal");
endmodule : riu_ret_assertions
bind riu_return_unit riu_ret_assertions chk_u (.*);
`default_nettype wire

// ==== verif/testbench.sv ====
`default_nettype none
module testbench
  import riu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic            clk = 0, rst = 1, vld = 0, psh = 0, ip = 0, hp = 0, pwe, cwe;
  logic [1:0]      ph;
  logic [15:0]     ins = '0, op;
  logic [PC_W-1:0] pa = '0, pc, e_pc[$];
  logic [7:0]      e_w[$];
  riu_ctx_type     sh = '0, lv, cx;
  int              error_cnt = 0, n_checks = 0, seed = 32'h0492_0c12;
  riu_return_unit dut_u (.CLK_I(clk), .RST_I(rst), .INSTR_I(ins), .INSTR_VALID_I(vld),
    .PUSH_I(psh), .PUSH_ADDR_I(pa), .IPEN_I(ip), .HIGH_PRIO_ACTIVE_I(hp), .SHADOW_I(sh),
    .LIVE_I(lv), .PC_O(pc), .PC_WE_O(pwe), .CTX_O(cx), .CTX_WE_O(cwe), .STATUS_WE_O(),
    .HIGH_PRIO_GLOBAL_IRQ_ENABLE_O(), .LOW_PRIO_GLOBAL_IRQ_ENABLE_O(), .FLUSH_O(),
    .STACK_TOP_VALUE_O(), .STACK_PTR_O(), .PHASE_O(ph));
  riu_regfile_model pm_u (.clk_i(clk), .we_i(cwe), .ctx_i(cx), .live_o(lv));
  task automatic cmp_pc(logic [PC_W-1:0] e, logic [PC_W-1:0] g);
    n_checks++;
    if (e !== g) begin error_cnt++; $display("mismatch pc exp %h got %h", e, g); end
  endtask : cmp_pc
  task automatic cmp_w(logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (e !== g) begin error_cnt++; $display("mismatch w exp %h got %h", e, g); end
  endtask : cmp_w
  task automatic wrap_up;
    error_cnt += e_pc.size() + e_w.size();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    if (pwe === 1'b1) cmp_pc(e_pc.size() ? e_pc.pop_front() : 'x, pc);
    if (cwe === 1'b1) cmp_w(e_w.size() ? e_w.pop_front() : 'x, cx.working);
  end
  initial forever #50 clk = ~clk;
  initial begin repeat (2000) @(posedge clk); error_cnt++; wrap_up; end
  initial begin
    sh <= 24'($random(seed));
    repeat (10) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk); psh <= 1; pa <= PC_W'($random(seed)); #1 e_pc.push_front(pa);
    end
    @(posedge clk); psh <= 0; e_pc.push_back('0); e_pc.push_back('0);
    // Last two returns pop an empty stack; the last is a high level return in priority mode
    for (int i = 0; i < 8; i++) begin
      op = i < 4 ? 16'h0010 + 16'(i) : i == 7 ? OP_IRQ_RET_BASE
         : {OP_LIT_RET_HI, 8'($random(seed))};
      if ((i > 3 && i < 7) || op[0]) e_w.push_back(i > 3 ? op[7:0] : sh.working);
      do @(posedge clk); while (ph !== PHASE_Q4);
      ins <= op; vld <= 1; ip <= i[0]; hp <= i[1];
      // Held into the flush cycle, where it must be ignored
      repeat (5) @(posedge clk); vld <= 0; repeat (3) @(posedge clk);
    end
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
